// File: rtl/ebtc_defs.svh
// Register map, field positions and reset values of the 8-bit timer channel.
// Assumes inclusion by bare name from the channel's design files.
`ifndef EBTC_DEFS_SVH
`define EBTC_DEFS_SVH

// Register indices on the 3-bit register port
`define EBTC_A_TIMER_CONTROL 3'h0
`define EBTC_A_TIMER_CONTROL_STATUS 3'h1
`define EBTC_A_COUNT_VALUE 3'h2
`define EBTC_A_TIME_CONSTANT_A 3'h3
`define EBTC_A_TIME_CONSTANT_B 3'h4
`define EBTC_A_SERIAL_TIMER_SHARED_CONTROL 3'h5

// Reset values
`define EBTC_RST_TIMER_CONTROL 8'h00
`define EBTC_RST_COUNT_VALUE 8'h00
`define EBTC_RST_TIME_CONSTANT 8'hFF
`define EBTC_RST_SHARED_CONTROL 8'h00
`define EBTC_RST_OUT_SEL 4'h0
`define EBTC_COUNT_MAX 8'hFF

// Timer control fields
`define EBTC_TC_MATCH_B_IE 7
`define EBTC_TC_MATCH_A_IE 6
`define EBTC_TC_OVF_IE 5
`define EBTC_TC_CLR_HI 4
`define EBTC_TC_CLR_LO 3
`define EBTC_TC_CKS_HI 2
`define EBTC_TC_CKS_LO 0

// Timer control/status fields
`define EBTC_TS_MATCH_FLAG_B 7
`define EBTC_TS_MATCH_FLAG_A 6
`define EBTC_TS_OVERFLOW_FLAG 5
`define EBTC_TS_RESERVED_ONE 1'h1

// Prescaler taps for the six internal clocks (bit k gives divide by 2^(k+1))
`define EBTC_PRESC_W 11
`define EBTC_TAP_DIV2 0
`define EBTC_TAP_DIV8 2
`define EBTC_TAP_DIV64 5
`define EBTC_TAP_DIV128 6
`define EBTC_TAP_DIV1024 9
`define EBTC_TAP_DIV2048 10

`endif

// File: rtl/ebtc_pkg.sv
// Types shared by the 8-bit timer channel files.
// Assumes nothing beyond a SystemVerilog compiler.
package ebtc_pkg;

  // Clock select codes of the timer control register
  typedef enum logic [2:0] {
    CKS_STOP0 = 3'b000,
    CKS_INT_A = 3'b001,
    CKS_INT_B = 3'b010,
    CKS_INT_C = 3'b011,
    CKS_STOP1 = 3'b100,
    CKS_EXT_RISE = 3'b101,
    CKS_EXT_FALL = 3'b110,
    CKS_EXT_BOTH = 3'b111
  } ebtc_cks_t;

  // Output action per match; code order equals priority order
  typedef enum logic [1:0] {
    ACT_KEEP = 2'b00,
    ACT_ZERO = 2'b01,
    ACT_ONE = 2'b10,
    ACT_TOGGLE = 2'b11
  } ebtc_act_t;

  // Counter clear selection
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_MATCH_A = 2'b01,
    CLR_MATCH_B = 2'b10,
    CLR_EXT_PIN = 2'b11
  } ebtc_clr_t;

endpackage

// File: rtl/ebtc_pin_sync.sv
// Three-stage synchroniser for a pin level; output changes once stages two and three agree.
// Assumes a pin asynchronous to clk and a synchronous active-high reset.
`timescale 1ns/100ps
module ebtc_pin_sync
  import ebtc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic pinIn, // Raw pin level
  output logic levelOut // Filtered level
);

  logic s1Reg;
  logic s2Reg;
  logic s3Reg;

  // Shift chain; only s2Reg reads s1Reg
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1Reg <= 1'b0;
      s2Reg <= 1'b0;
      s3Reg <= 1'b0;
      levelOut <= 1'b0;
    end
    else
    begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      if (s2Reg == s3Reg)
        levelOut <= s3Reg;
    end
  end

endmodule

// File: rtl/ebtc_clk_sel.sv
// Prescaler and count-source selector: one-cycle count pulse per counting edge of the chosen source, the falling edge for internal clocks.
// Assumes a filtered external clock level on the same clock.
`timescale 1ns/100ps
`include "ebtc_defs.svh"
module ebtc_clk_sel
  import ebtc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [2:0] cks, // Clock select code
  input wire logic icks, // Internal clock select bit
  input wire logic extLevel, // Filtered external clock level
  output logic countPulse // One-cycle count enable
);

  logic [`EBTC_PRESC_W-1:0] prescReg;
  logic prevReg;
  logic curLevel;
  logic selA;
  logic selB;
  logic selC;
  ebtc_cks_t mode;

  // Internal sources; stopped codes read as a low level
  assign mode = ebtc_cks_t'(cks);
  assign selA = icks ? prescReg[`EBTC_TAP_DIV2] : prescReg[`EBTC_TAP_DIV8];
  assign selB = icks ? prescReg[`EBTC_TAP_DIV128] : prescReg[`EBTC_TAP_DIV64];
  assign selC = icks ? prescReg[`EBTC_TAP_DIV2048] : prescReg[`EBTC_TAP_DIV1024];
  assign curLevel = (mode == CKS_INT_A) ? selA :
                    (mode == CKS_INT_B) ? selB :
                    (mode == CKS_INT_C) ? selC :
                    cks[2] && (cks[1:0] != 2'b00) ? extLevel : 1'b0;

  // Edge of the muxed level, so a source switch can itself make one pulse
  always_comb
  begin
    case (mode)
      CKS_EXT_RISE: countPulse = !prevReg && curLevel;
      CKS_EXT_BOTH: countPulse = prevReg != curLevel;
      default: countPulse = prevReg && !curLevel;
    endcase
  end

  // Free-running prescaler and previous level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prescReg <= '0;
      prevReg <= 1'b0;
    end
    else
    begin
      prescReg <= prescReg + 1'b1;
      prevReg <= curLevel;
    end
  end

endmodule

// File: rtl/ebtc_timer.sv
// One channel of an 8-bit up-counting timer with two compares, output pin and three interrupt lines.
// Assumes a one-cycle register port with read data one cycle later, and external pins
// asynchronous to clk.
`timescale 1ns/100ps
`include "ebtc_defs.svh"

module ebtc_timer
  import ebtc_pkg::*;
#(
  parameter bit CHAN_USES_HI = 1'b0 // Channel takes the high internal select bit
)
(
  input wire logic clk, // System clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [2:0] regAddr, // Register index
  input wire logic [7:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [7:0] regRdata, // Read data, cycle after the strobe
  input wire logic extCountInput, // External clock pin
  input wire logic extResetInput, // External counter reset pin
  output logic timerOut, // Timer output level
  output logic timerOutEn, // Timer output drive enable
  output logic matchAIrq, // Match A request
  output logic matchBIrq, // Match B request
  output logic overflowIrq // Overflow request
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0] timerControlReg;
  logic [7:0] sharedControlReg;
  logic [7:0] countReg;
  logic [7:0] countNext;
  logic [7:0] constAReg;
  logic [7:0] constBReg;
  logic [3:0] outSelReg;
  logic flagAReg;
  logic flagBReg;
  logic flagOvfReg;
  logic armAReg;
  logic armBReg;
  logic armOvfReg;
  logic timerOutNext;
  logic extCountLevel;
  logic extResetLevel;
  logic extResetPrevReg;
  logic countPulse;
  logic wrControl;
  logic wrStatus;
  logic wrCount;
  logic wrConstA;
  logic wrConstB;
  logic wrShared;
  logic rdStatus;
  logic matchA;
  logic matchB;
  logic extClear;
  logic matchClear;
  logic clearNow;
  logic wrapNow;
  logic swClrA;
  logic swClrB;
  logic swClrOvf;
  logic [7:0] statusView;
  logic [7:0] readMux;
  logic icksBit;
  ebtc_clr_t clrSel;
  ebtc_act_t actA;
  ebtc_act_t actB;
  ebtc_act_t actWin;

  // Strobe decode
  assign wrControl = regWr && (regAddr == `EBTC_A_TIMER_CONTROL);
  assign wrStatus = regWr && (regAddr == `EBTC_A_TIMER_CONTROL_STATUS);
  assign wrCount = regWr && (regAddr == `EBTC_A_COUNT_VALUE);
  assign wrConstA = regWr && (regAddr == `EBTC_A_TIME_CONSTANT_A);
  assign wrConstB = regWr && (regAddr == `EBTC_A_TIME_CONSTANT_B);
  assign wrShared = regWr && (regAddr == `EBTC_A_SERIAL_TIMER_SHARED_CONTROL);
  assign rdStatus = regRd && (regAddr == `EBTC_A_TIMER_CONTROL_STATUS);

  // Status view: flags, reserved one, output selects
  assign statusView = {flagBReg, flagAReg, flagOvfReg, `EBTC_TS_RESERVED_ONE, outSelReg};

  // Read selection; unmapped indices read zero
  assign readMux = (regAddr == `EBTC_A_TIMER_CONTROL) ? timerControlReg :
                   (regAddr == `EBTC_A_TIMER_CONTROL_STATUS) ? statusView :
                   (regAddr == `EBTC_A_COUNT_VALUE) ? countReg :
                   (regAddr == `EBTC_A_TIME_CONSTANT_A) ? constAReg :
                   (regAddr == `EBTC_A_TIME_CONSTANT_B) ? constBReg :
                   (regAddr == `EBTC_A_SERIAL_TIMER_SHARED_CONTROL) ? sharedControlReg : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Pins and count source

  // External clock pin filter
  ebtc_pin_sync uSyncCount (
    .clk(clk),
    .rst(rst),
    .pinIn(extCountInput),
    .levelOut(extCountLevel)
  );

  // External reset pin filter
  ebtc_pin_sync uSyncReset (
    .clk(clk),
    .rst(rst),
    .pinIn(extResetInput),
    .levelOut(extResetLevel)
  );

  // Channel picks one bit of the shared control register
  assign icksBit = CHAN_USES_HI ? sharedControlReg[1] : sharedControlReg[0];

  // Count source and edge selection
  ebtc_clk_sel uClkSel (
    .clk(clk),
    .rst(rst),
    .cks(timerControlReg[`EBTC_TC_CKS_HI:`EBTC_TC_CKS_LO]),
    .icks(icksBit),
    .extLevel(extCountLevel),
    .countPulse(countPulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare, clear and count

  // Match only in the last equal state, i.e. with the count pulse; constant write masks it
  assign matchA = countPulse && (countReg == constAReg) && !wrConstA;
  assign matchB = countPulse && (countReg == constBReg) && !wrConstB;

  // Clear sources
  assign clrSel = ebtc_clr_t'(timerControlReg[`EBTC_TC_CLR_HI:`EBTC_TC_CLR_LO]);
  assign extClear = (clrSel == CLR_EXT_PIN) && extResetLevel && !extResetPrevReg;
  assign matchClear = ((clrSel == CLR_MATCH_A) && matchA) || ((clrSel == CLR_MATCH_B) && matchB);
  assign clearNow = extClear || matchClear;
  assign wrapNow = countPulse && !clearNow && !wrCount && (countReg == `EBTC_COUNT_MAX);

  // Counter next value: clear, then write, then increment
  always_comb
  begin
    if (clearNow)
      countNext = `EBTC_RST_COUNT_VALUE;
    else if (wrCount)
      countNext = regWdata;
    else if (countPulse)
      countNext = countReg + 8'h01;
    else
      countNext = countReg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer output

  // Larger action code has higher priority
  assign actA = matchA ? ebtc_act_t'(outSelReg[1:0]) : ACT_KEEP;
  assign actB = matchB ? ebtc_act_t'(outSelReg[3:2]) : ACT_KEEP;
  assign actWin = (actA > actB) ? actA : actB;

  // Apply winning action
  always_comb
  begin
    case (actWin)
      ACT_ZERO: timerOutNext = 1'b0;
      ACT_ONE: timerOutNext = 1'b1;
      ACT_TOGGLE: timerOutNext = !timerOut;
      default: timerOutNext = timerOut;
    endcase
  end

  assign timerOutEn = |outSelReg;

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt requests

  // A flag clears only by writing 0 after it was read as 1
  assign swClrA = wrStatus && !regWdata[`EBTC_TS_MATCH_FLAG_A] && armAReg;
  assign swClrB = wrStatus && !regWdata[`EBTC_TS_MATCH_FLAG_B] && armBReg;
  assign swClrOvf = wrStatus && !regWdata[`EBTC_TS_OVERFLOW_FLAG] && armOvfReg;

  // Separate lines; controller ranks A over B over overflow
  assign matchAIrq = flagAReg && timerControlReg[`EBTC_TC_MATCH_A_IE];
  assign matchBIrq = flagBReg && timerControlReg[`EBTC_TC_MATCH_B_IE];
  assign overflowIrq = flagOvfReg && timerControlReg[`EBTC_TC_OVF_IE];

  ////////////////////////////////////////////////////////////////////////////
  // Clocked state

  // Control registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      timerControlReg <= `EBTC_RST_TIMER_CONTROL;
      sharedControlReg <= `EBTC_RST_SHARED_CONTROL;
      outSelReg <= `EBTC_RST_OUT_SEL;
      constAReg <= `EBTC_RST_TIME_CONSTANT;
      constBReg <= `EBTC_RST_TIME_CONSTANT;
    end
    else
    begin
      if (wrControl)
        timerControlReg <= regWdata;
      if (wrShared)
        sharedControlReg <= regWdata;
      if (wrStatus)
        outSelReg <= regWdata[3:0];
      if (wrConstA)
        constAReg <= regWdata;
      if (wrConstB)
        constBReg <= regWdata;
    end
  end

  // Counter, output pin, reset-pin edge and read data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      countReg <= `EBTC_RST_COUNT_VALUE;
      timerOut <= 1'b0;
      extResetPrevReg <= 1'b0;
      regRdata <= 8'h00;
    end
    else
    begin
      countReg <= countNext;
      timerOut <= timerOutNext;
      extResetPrevReg <= extResetLevel;
      regRdata <= regRd ? readMux : 8'h00;
    end
  end

  // Flags: hardware set wins over software clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flagAReg <= 1'b0;
      flagBReg <= 1'b0;
      flagOvfReg <= 1'b0;
    end
    else
    begin
      flagAReg <= matchA || (flagAReg && !swClrA);
      flagBReg <= matchB || (flagBReg && !swClrB);
      flagOvfReg <= wrapNow || (flagOvfReg && !swClrOvf);
    end
  end

  // Arm bits remember a read that saw the flag set
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      armAReg <= 1'b0;
      armBReg <= 1'b0;
      armOvfReg <= 1'b0;
    end
    else
    begin
      armAReg <= flagAReg && !swClrA && (armAReg || rdStatus);
      armBReg <= flagBReg && !swClrB && (armBReg || rdStatus);
      armOvfReg <= flagOvfReg && !swClrOvf && (armOvfReg || rdStatus);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cbClk @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seqWrap;
    countPulse && !clearNow && !wrCount && (countReg == 8'hFF);
  endsequence

  sequence seqMatchAClear;
    matchA && (clrSel == CLR_MATCH_A) && !extClear;
  endsequence

  AST_OVERFLOW_SETS: assert property (seqWrap |=> flagOvfReg && (countReg == 8'h00))
    else $error("overflow flag not set on wrap");
  AST_MATCH_A_FLAG: assert property (matchA |=> flagAReg)
    else $error("match A did not set its flag");
  AST_MATCH_NEEDS_PULSE: assert property ((matchA || matchB) |-> countPulse)
    else $error("match outside the counting state");
  AST_CLEAR_ON_A: assert property (seqMatchAClear |=> (countReg == 8'h00))
    else $error("counter not cleared on match A");
  AST_WRITE_BEATS_COUNT: assert property
    (wrCount && countPulse && !clearNow |=> countReg == $past(regWdata))
    else $error("counter write lost to increment");
  AST_CLEAR_BEATS_WRITE: assert property (wrCount && clearNow |=> countReg == 8'h00)
    else $error("counter write not dropped on clear");
  AST_CONST_WRITE_MASKS: assert property (wrConstA && countPulse |=> !$rose(flagAReg))
    else $error("match not suppressed by constant write");
  AST_TOGGLE_A: assert property
    (matchA && !matchB && (outSelReg[1:0] == 2'b11) |=> timerOut != $past(timerOut))
    else $error("output did not toggle on match A");
  AST_PRIORITY_ONE: assert property (matchA && matchB && (outSelReg == 4'b0110) |=> timerOut)
    else $error("drive-1 lost to drive-0");
  AST_IRQ_FOLLOWS: assert property
    (matchB && timerControlReg[`EBTC_TC_MATCH_B_IE] && !wrControl |=> matchBIrq)
    else $error("match B request not raised");
  AST_EXT_CLEAR: assert property
    ((clrSel == CLR_EXT_PIN) && !wrControl ##0 $rose(extResetLevel) |=> countReg == 8'h00)
    else $error("external reset did not clear counter");

  // Both matches with a toggle selected: toggle outranks drive-1 and drive-0
  sequence seqToggleWins;
    matchA && matchB && ((outSelReg[1:0] == 2'b11) || (outSelReg[3:2] == 2'b11));
  endsequence

  AST_PRIORITY_TOGGLE: assert property (seqToggleWins |=> timerOut != $past(timerOut))
    else $error("toggle lost to another output action");
  AST_MATCH_B_FLAG: assert property (matchB |=> flagBReg)
    else $error("match B did not set its flag");
  AST_FLAG_WAITS_PULSE: assert property ((countReg == constAReg) && !countPulse |=> !$rose(flagAReg))
    else $error("flag A set before the counting state");
  AST_NO_SW_SET: assert property
    (wrStatus && regWdata[`EBTC_TS_OVERFLOW_FLAG] && !flagOvfReg && !wrapNow |=> !flagOvfReg)
    else $error("overflow flag set by software");
  AST_IRQ_DROPS: assert property (swClrA && !matchA |=> !matchAIrq)
    else $error("match A request stayed after flag clear");
  AST_SHARED_READ: assert property
    (regRd && (regAddr == `EBTC_A_SERIAL_TIMER_SHARED_CONTROL) |=> regRdata == $past(sharedControlReg))
    else $error("shared control read back wrong");

endmodule

// File: tb/ebtc_pin_drv.sv
// Model of the external clock and counter reset pins beside the timer channel.
// Assumes the bench calls its tasks; pins rest low between pulses.
`timescale 1ns/100ps
module ebtc_pin_drv
(
  input wire logic clk, // System clock
  output logic extCountInput, // External clock pin
  output logic extResetInput // External counter reset pin
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle level of both pins
  initial
  begin
    extCountInput = 1'b0;
    extResetInput = 1'b0;
  end

  // Clock pulses six cycles high and six low, wide enough for both-edge counting
  task automatic cntPulses(input int n);
    repeat (n)
    begin
      repeat (6) @(posedge clk);
      extCountInput <= 1'b1;
      repeat (6) @(posedge clk);
      extCountInput <= 1'b0;
    end
  endtask

  // One reset pulse of four cycles
  task automatic rstPulse();
    repeat (2) @(posedge clk);
    extResetInput <= 1'b1;
    repeat (4) @(posedge clk);
    extResetInput <= 1'b0;
  endtask
endmodule

// File: tb/eight_bit_timer_channel_test.sv
// Self-checking bench for one 8-bit timer channel.
// Assumes the pin model drives the external pins; bus signals move just after a rising edge.
`timescale 1ns/100ps
`include "ebtc_defs.svh"
module eight_bit_timer_channel_test;
  logic clk, rst, regWr, regRd;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, d;
  logic timerOut, timerOutEn, matchAIrq, matchBIrq, overflowIrq, extCountInput, extResetInput;
  int fails = 0;
  int nChecks = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and pin model
  ebtc_timer #(.CHAN_USES_HI(1'b0)) dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extCountInput(extCountInput),
    .extResetInput(extResetInput), .timerOut(timerOut), .timerOutEn(timerOutEn), .matchAIrq(matchAIrq),
    .matchBIrq(matchBIrq), .overflowIrq(overflowIrq));
  ebtc_pin_drv pins_u (.clk(clk), .extCountInput(extCountInput), .extResetInput(extResetInput));

  // Clock at 250 MHz
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cycle ceiling against a hang
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and checking tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks = nChecks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Verdict and end of run
  task report_and_stop();
    if (fails == 0 && nChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped index, shared register read/write
  task automatic t_reset();
    logic [7:0] e [7] = '{8'h00, 8'h10, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
    chk({3'h0, timerOut, timerOutEn, matchAIrq, matchBIrq, overflowIrq}, 8'h00);
    wr(3'h6, 8'h5A);
    for (int a = 0; a < 7; a++)
    begin
      rd(a[2:0]);
      chk(d, e[a]);
    end
    wr(`EBTC_A_SERIAL_TIMER_SHARED_CONTROL, 8'hA5);
    rd(`EBTC_A_SERIAL_TIMER_SHARED_CONTROL);
    chk(d, 8'hA5);
  endtask

  // Six internal rates, each run for twenty source periods
  task automatic t_rates();
    logic [2:0] code [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3};
    int dv [6] = '{8, 2, 64, 128, 1024, 2048};
    for (int i = 0; i < 6; i++)
    begin
      wr(`EBTC_A_TIMER_CONTROL, 8'h00);
      wr(`EBTC_A_SERIAL_TIMER_SHARED_CONTROL, 8'(i % 2));
      wr(`EBTC_A_COUNT_VALUE, 8'h00);
      wr(`EBTC_A_TIMER_CONTROL, {5'h00, code[i]});
      idle(dv[i] * 20);
      wr(`EBTC_A_TIMER_CONTROL, 8'h00);
      rd(`EBTC_A_COUNT_VALUE);
      chk(8'(d >= 8'h14 && d <= 8'h17), 8'h01);
    end
  endtask

  // Clear on match A, flag, request line and software clear
  task automatic t_match();
    wr(`EBTC_A_COUNT_VALUE, 8'h00);
    wr(`EBTC_A_TIME_CONSTANT_A, 8'h03);
    wr(`EBTC_A_TIMER_CONTROL, 8'h49);
    idle(40);
    chk(8'(matchAIrq), 8'h01);
    chk({6'h00, matchBIrq, overflowIrq}, 8'h00);
    rd(`EBTC_A_COUNT_VALUE);
    chk(8'(d <= 8'h03), 8'h01);
    wr(`EBTC_A_TIMER_CONTROL, 8'h48);
    rd(`EBTC_A_TIMER_CONTROL_STATUS);
    chk(d, 8'h50);
    wr(`EBTC_A_TIMER_CONTROL_STATUS, 8'h00);
    idle(1);
    chk(8'(matchAIrq), 8'h00);
    wr(`EBTC_A_TIMER_CONTROL_STATUS, 8'hE0);
    rd(`EBTC_A_TIMER_CONTROL_STATUS);
    chk(d, 8'h10);
  endtask

  // Wrap from the top count sets the overflow flag
  task automatic t_ovf();
    wr(`EBTC_A_TIMER_CONTROL, 8'h00);
    wr(`EBTC_A_COUNT_VALUE, 8'hFC);
    wr(`EBTC_A_TIMER_CONTROL, 8'h21);
    idle(14);
    wr(`EBTC_A_TIMER_CONTROL, 8'h20);
    chk(8'(overflowIrq), 8'h01);
    rd(`EBTC_A_TIMER_CONTROL_STATUS);
    chk(8'(d[`EBTC_TS_OVERFLOW_FLAG]), 8'h01);
    wr(`EBTC_A_TIMER_CONTROL_STATUS, 8'h00);
    idle(1);
    chk(8'(overflowIrq), 8'h00);
  endtask

  // Autonomous pulse output, then toggle winning over drive-1
  task automatic high_cycles(output logic [7:0] n);
    n = 8'h00;
    repeat (64)
    begin
      @(posedge clk);
      #1;
      n = n + 8'(timerOut);
    end
  endtask

  task automatic t_pulse();
    logic [7:0] n;
    wr(`EBTC_A_TIME_CONSTANT_B, 8'h03);
    wr(`EBTC_A_TIME_CONSTANT_A, 8'h07);
    wr(`EBTC_A_TIMER_CONTROL_STATUS, 8'h06);
    wr(`EBTC_A_TIMER_CONTROL, 8'h89);
    idle(40);
    chk(8'(timerOutEn), 8'h01);
    chk(8'(matchBIrq), 8'h01);
    high_cycles(n);
    chk(n, 8'h20);
    wr(`EBTC_A_TIME_CONSTANT_B, 8'h07);
    wr(`EBTC_A_TIMER_CONTROL_STATUS, 8'h0B);
    idle(40);
    high_cycles(n);
    chk(n, 8'h20);
    wr(`EBTC_A_TIME_CONSTANT_B, 8'hFF);
    idle(40);
    high_cycles(n);
    chk(n, 8'h20);
  endtask

  // Counter and constant writes landing on count pulses at the /2 rate
  task automatic t_contend();
    wr(`EBTC_A_TIMER_CONTROL, 8'h01);
    wr(`EBTC_A_TIME_CONSTANT_A, 8'h03);
    idle(1);
    wr(`EBTC_A_TIME_CONSTANT_A, 8'h03);
    wr(`EBTC_A_COUNT_VALUE, 8'h40);
    idle(1);
    wr(`EBTC_A_COUNT_VALUE, 8'h40);
    wr(`EBTC_A_TIMER_CONTROL, 8'h00);
    rd(`EBTC_A_COUNT_VALUE);
    chk(8'(d == 8'h41 || d == 8'h42), 8'h01);
    rd(`EBTC_A_TIME_CONSTANT_A);
    chk(d, 8'h03);
    wr(`EBTC_A_COUNT_VALUE, 8'h00);
  endtask

  // External clock on each edge mode, then the external reset pin
  task automatic t_ext();
    logic [7:0] e [3] = '{8'h04, 8'h04, 8'h08};
    for (int i = 0; i < 3; i++)
    begin
      wr(`EBTC_A_TIMER_CONTROL, 8'(5 + i));
      idle(8);
      wr(`EBTC_A_COUNT_VALUE, 8'h00);
      pins_u.cntPulses(4);
      idle(10);
      rd(`EBTC_A_COUNT_VALUE);
      chk(d, e[i]);
    end
    wr(`EBTC_A_TIMER_CONTROL, 8'h00);
    wr(`EBTC_A_COUNT_VALUE, 8'h55);
    pins_u.rstPulse();
    idle(10);
    rd(`EBTC_A_COUNT_VALUE);
    chk(d, 8'h55);
    wr(`EBTC_A_TIMER_CONTROL, 8'h18);
    pins_u.rstPulse();
    idle(10);
    rd(`EBTC_A_COUNT_VALUE);
    chk(d, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 3'h0;
    regWdata = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rates();
    wr(`EBTC_A_SERIAL_TIMER_SHARED_CONTROL, 8'h01);
    t_match();
    t_ovf();
    t_contend();
    t_pulse();
    t_ext();
    report_and_stop();
  end
endmodule
